// File: bench/dfac_mem_model.sv
// Behavioural memory side: answers each outstanding transfer after a short or long delay
`timescale 1ns/1ns
module dfac_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic slow,
  output logic done
);
  logic gap;
  logic [2:0] lag;
  // One pulse per transfer, then two cycles off so a stale request is not answered twice
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done <= 1'b0;
      gap <= 1'b0;
      lag <= 3'h0;
    end
    else
    begin
      done <= 1'b0;
      gap <= done;
      if (done || gap || !go)
        lag <= 3'h0;
      else if (lag >= (slow ? 3'h4 : 3'h0))
        done <= 1'b1;
      else
        lag <= lag + 3'h1;
    end
  end
endmodule : dfac_mem_model

// File: bench/dfac_top_assertions.sv
// Port checks for the DMA full address control block
`timescale 1ns/1ns
module dfac_top_assertions #(
  parameter int AW = 32
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic STANDBY,
  input wire logic NMI,
  input wire logic XFER_DONE,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic XFER_GO,
  input wire logic XFER_WORD,
  input wire logic [AW-1:0] SRC_ADDR,
  input wire logic TRANSFER_END_INTERRUPT,
  input wire logic FULL_MODE
);
  logic [3:0] quiet;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // Cycles since a register write, a finished transfer or standby
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      quiet <= 4'h0;
    else if ((S_AXI_WVALID && S_AXI_WREADY) || XFER_DONE || STANDBY)
      quiet <= 4'h0;
    else if (quiet != 4'hF)
      quiet <= quiet + 4'h1;
  end
  property p_std_clear;
    STANDBY |-> ##2 (!XFER_GO && !FULL_MODE && !XFER_WORD);
  endproperty
  a_std_clear: assert property (p_std_clear) else $error("standby left outputs set");
  property p_std_keep;
    STANDBY [*3] |-> $stable(SRC_ADDR);
  endproperty
  a_std_keep: assert property (p_std_keep) else $error("standby moved source");
  property p_nmi_stop;
    NMI |-> ##[1:3] !XFER_GO;
  endproperty
  a_nmi_stop: assert property (p_nmi_stop) else $error("transfer not stopped");
  property p_int_pulse;
    TRANSFER_END_INTERRUPT |=> !TRANSFER_END_INTERRUPT;
  endproperty
  a_int_pulse: assert property (p_int_pulse) else $error("end pulse too long");
  property p_aw_busy;
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
  endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("write taken during response");
  property p_r_once;
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
  endproperty
  a_r_once: assert property (p_r_once) else $error("read answered twice");
  property p_src_cause;
    !$stable(SRC_ADDR) |-> quiet < 4'h6;
  endproperty
  a_src_cause: assert property (p_src_cause) else $error("source moved alone");
  property p_word_cause;
    $changed(XFER_WORD) |-> quiet < 4'h6;
  endproperty
  a_word_cause: assert property (p_word_cause) else $error("size moved alone");
  c_go: cover property ($rose(XFER_GO));
  c_int: cover property (TRANSFER_END_INTERRUPT);
  c_nmi: cover property (NMI && XFER_GO);
endmodule : dfac_top_assertions
bind dfac_top dfac_top_assertions #(.AW(AW)) i_dfac_top_assertions (
  .CLK(CLK), .RST_N(RST_N), .STANDBY(STANDBY), .NMI(NMI), .XFER_DONE(XFER_DONE),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .XFER_GO(XFER_GO), .XFER_WORD(XFER_WORD), .SRC_ADDR(SRC_ADDR),
  .TRANSFER_END_INTERRUPT(TRANSFER_END_INTERRUPT), .FULL_MODE(FULL_MODE)
);

// File: bench/tb_dfac_top.sv
// Self-checking bench for the DMA full address control block
`timescale 1ns/1ns
`include "dfac_map.svh"
module tb_dfac_top;
  localparam logic [7:0] o_n1 = `DFAC_OFF_COUNT_FIRST;
  localparam logic [7:0] o_n2 = `DFAC_OFF_COUNT_SECOND;
  localparam logic [7:0] o_c1 = `DFAC_OFF_CTRL_FIRST;
  localparam logic [7:0] o_c2 = `DFAC_OFF_CTRL_SECOND;
  localparam logic [7:0] o_src = `DFAC_OFF_SRC_ADDR;
  localparam logic [7:0] o_dst = `DFAC_OFF_DST_ADDR;
  logic clk, rst_n = 1'b0, standby = 1'b0, nmi = 1'b0, xreq = 1'b0, slow = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, src, dst, d;
  logic done, go, word, tei, full, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  int error_cnt = 0, total_checks = 0, n_done = 0, n_int = 0, n_go = 0, k;
  dfac_top i_dfac_top (
    .CLK(clk), .RST_N(rst_n), .STANDBY(standby), .NMI(nmi), .XFER_REQ(xreq), .XFER_DONE(done),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BVALID(bvalid),
    .S_AXI_BRESP(bresp), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RVALID(rvalid), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RREADY(rready), .XFER_GO(go), .XFER_WORD(word), .SRC_ADDR(src), .DST_ADDR(dst),
    .TRANSFER_END_INTERRUPT(tei), .FULL_MODE(full)
  );
  dfac_mem_model i_dfac_mem_model (.clk(clk), .rst_n(rst_n), .go(go), .slow(slow), .done(done));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Sampled mid-cycle, where the design's registered outputs are settled
  always @(negedge clk)
  begin
    n_done += (done && go) ? 1 : 0;
    n_int += tei ? 1 : 0;
    n_go += go ? 1 : 0;
  end
  task wrap_up;
  begin
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask : wrap_up
  task fail(input string what);
  begin
    error_cnt++;
    $display("unexpected %s: expected answer, seen none", what);
    wrap_up;
  end
  endtask : fail
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
  begin
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  end
  endtask : check
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    logic pa, pw, pq, pr;
    int n;
  begin
    @(posedge clk);
    if (w)
    begin
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end
    else
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    pr = 1'b0;
    for (n = 0; n < 40 && !pr; n++)
    begin
      @(negedge clk);
      pa = awvalid && awready;
      pw = wvalid && wready;
      pq = arvalid && arready;
      pr = w ? bvalid : rvalid;
      resp = w ? bresp : rresp;
      d = rdata;
      @(posedge clk);
      if (pa)
        awvalid <= 1'b0;
      if (pw)
        wvalid <= 1'b0;
      if (pq)
        arvalid <= 1'b0;
      if (pr)
      begin
        bready <= 1'b0;
        rready <= 1'b0;
      end
    end
    if (!pr)
      fail("bus answer");
  end
  endtask : bus
  task rc(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
  begin
    bus(1'b0, a, 32'h0);
    check(what, exp, d & m);
  end
  endtask : rc
  task wait_off;
  begin
    for (k = 0; k < 80; k++)
    begin
      bus(1'b0, o_c1, 32'h0);
      if (d[7] === 1'b0)
        break;
    end
    if (k == 80)
      fail("enable clear");
  end
  endtask : wait_off
  task t_reset;
  begin
    rc("control first", o_c1, 32'hFF, 32'h0);
    check("full mode", 32'h0, 32'(full));
    rc("status", `DFAC_OFF_STATUS, 32'hF, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    check("read resp", 32'(`DFAC_RESP_SLVERR), 32'(resp));
    bus(1'b1, 8'h40, 32'h0);
    check("write resp", 32'(`DFAC_RESP_SLVERR), 32'(resp));
    $display("test reset finished");
  end
  endtask : t_reset
  task t_normal;
  begin
    bus(1'b1, o_n1, 32'h3);
    bus(1'b1, o_n2, 32'h5);
    bus(1'b1, o_src, 32'h100);
    bus(1'b1, o_dst, 32'h500);
    n_done = 0;
    n_int = 0;
    bus(1'b0, o_c2, 32'h0);
    bus(1'b1, o_c2, 32'h80);
    bus(1'b0, o_c1, 32'h0);
    bus(1'b1, o_c1, 32'hDE);
    wait_off;
    check("done count", 32'h3, n_done);
    check("end interrupts", 32'h1, n_int);
    check("source", 32'h106, src);
    check("destination", 32'h500, dst);
    check("word size", 32'h1, 32'(word));
    check("full mode", 32'h1, 32'(full));
    rc("count first", o_n1, 32'hFFFF, 32'h0);
    rc("count second", o_n2, 32'hFFFF, 32'h5);
    $display("test normal finished");
  end
  endtask : t_normal
  task t_block;
  begin
    slow <= 1'b1;
    bus(1'b1, o_n1, 32'h0202);
    bus(1'b1, o_n2, 32'h2);
    bus(1'b1, o_src, 32'h200);
    bus(1'b1, o_c2, 32'h82);
    n_done = 0;
    n_int = 0;
    bus(1'b0, o_c1, 32'h0);
    bus(1'b1, o_c1, 32'hB7);
    wait_off;
    check("done count", 32'h4, n_done);
    check("end interrupts", 32'h0, n_int);
    check("source", 32'h1FC, src);
    check("word size", 32'h0, 32'(word));
    rc("count first", o_n1, 32'hFFFF, 32'h0202);
    rc("count second", o_n2, 32'hFFFF, 32'h0);
    $display("test block finished");
  end
  endtask : t_block
  task t_nmi;
    int g;
  begin
    standby <= 1'b1;
    cyc(3);
    standby <= 1'b0;
    rc("control second", o_c2, 32'hFF, 32'h0);
    bus(1'b1, o_c1, 32'h86);
    rc("control first", o_c1, 32'hFF, 32'h06);
    rc("count first", o_n1, 32'hFFFF, 32'h0202);
    xreq <= 1'b1;
    g = n_go;
    cyc(8);
    check("go while off", g, n_go);
    xreq <= 1'b0;
    bus(1'b1, o_n1, 32'h4);
    bus(1'b1, o_src, 32'h300);
    bus(1'b1, o_c1, 32'h86);
    cyc(8);
    check("go without master", g, n_go);
    bus(1'b0, o_c2, 32'h0);
    bus(1'b1, o_c2, 32'h86);
    cyc(8);
    check("go without request", g, n_go);
    n_done = 0;
    xreq <= 1'b1;
    for (k = 0; k < 60 && n_done == 0; k++)
      @(posedge clk);
    if (n_done == 0)
      fail("first transfer");
    nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    cyc(4);
    g = n_go;
    cyc(12);
    check("go after nmi", g, n_go);
    rc("control second", o_c2, 32'hFF, 32'h06);
    bus(1'b1, o_c2, 32'h86);
    wait_off;
    xreq <= 1'b0;
    check("done count", 32'h4, n_done);
    check("source", 32'h300, src);
    $display("test nmi finished");
  end
  endtask : t_nmi
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_normal;
    t_block;
    t_nmi;
    wrap_up;
  end
endmodule : tb_dfac_top

// File: inc/dfac_map.svh
// Register offsets, field positions, reset values, step sizes and response codes for the DMA full address control block
`ifndef DFAC_MAP_SVH
`define DFAC_MAP_SVH
`define DFAC_OFF_COUNT_FIRST 8'h00
`define DFAC_OFF_COUNT_SECOND 8'h04
`define DFAC_OFF_CTRL_FIRST 8'h08
`define DFAC_OFF_CTRL_SECOND 8'h0C
`define DFAC_OFF_SRC_ADDR 8'h10
`define DFAC_OFF_DST_ADDR 8'h14
`define DFAC_OFF_STATUS 8'h18
`define DFAC_OFF_CONTROL 8'h1C
`define DFAC_CTRL_RESET 8'h00
`define DFAC_BIT_ENABLE 7
`define DFAC_BIT_SIZE 6
`define DFAC_BIT_SRC_DIR 5
`define DFAC_BIT_SRC_STEP 4
`define DFAC_BIT_END_IE 3
`define DFAC_BIT_FULL_HI 2
`define DFAC_BIT_FULL_LO 1
`define DFAC_BIT_BLOCK 0
`define DFAC_BIT_MASTER 7
`define DFAC_SRC_SEL_LSB 0
`define DFAC_SRC_SEL_W 3
`define DFAC_SRC_AUTO_BURST 3'h0
`define DFAC_SRC_AUTO_STEAL 3'h2
`define DFAC_STEP_BYTE 32'h00000001
`define DFAC_STEP_WORD 32'h00000002
`define DFAC_RESP_OKAY 2'h0
`define DFAC_RESP_SLVERR 2'h2
`endif

// File: inc/dfac_pkg.sv
// Types shared by the DMA full address control block
package dfac_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } dfac_wreq_t;
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } dfac_rresp_t;
  typedef enum logic [1:0] {
    DFAC_IDLE = 2'b00,
    DFAC_ARMED = 2'b01,
    DFAC_MOVE = 2'b11
  } dfac_state_t;
endpackage : dfac_pkg

// File: src/dfac_axil.sv
// AXI4-Lite slave front end: takes one write and one read, hands them on as single-cycle strobes
`timescale 1ns/1ns
`include "dfac_map.svh"
module dfac_axil
  import dfac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic bvalid,
  output logic [1:0] bresp,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic rvalid,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic rready,
  output logic wr_stb,
  output dfac_wreq_t wr_req,
  input wire logic wr_err,
  output logic rd_stb,
  output logic [7:0] rd_addr,
  input wire dfac_rresp_t rd_resp
);
  logic have_aw;
  logic have_w;

  // Address and data may come in either order
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      wr_stb <= 1'b0;
      wr_req <= '0;
      awready <= 1'b0;
      wready <= 1'b0;
    end
    else
    begin
      wr_stb <= 1'b0;
      // Ready drops on a take and comes back only once the response has gone
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        have_aw <= 1'b1;
        wr_req.addr <= {24'h000000, awaddr};
      end
      else if (!have_aw && !bvalid && !wr_stb)
        awready <= 1'b1;
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        have_w <= 1'b1;
        wr_req.data <= wdata;
        wr_req.strb <= wstrb;
      end
      else if (!have_w && !bvalid && !wr_stb)
        wready <= 1'b1;
      if (have_aw && have_w)
      begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        wr_stb <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid <= 1'b0;
      bresp <= `DFAC_RESP_OKAY;
    end
    else if (wr_stb)
    begin
      bvalid <= 1'b1;
      bresp <= wr_err ? `DFAC_RESP_SLVERR : `DFAC_RESP_OKAY;
    end
    else if (bvalid && bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_stb <= 1'b0;
      rd_addr <= 8'h00;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `DFAC_RESP_OKAY;
    end
    else
    begin
      rd_stb <= arvalid && arready;
      if (arvalid && arready)
        rd_addr <= araddr;
      if (arvalid && arready)
        arready <= 1'b0;
      else if (!rvalid && !rd_stb)
        arready <= 1'b1;
      if (rd_stb)
      begin
        rvalid <= 1'b1;
        rdata <= rd_resp.data;
        rresp <= rd_resp.resp;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end
endmodule : dfac_axil

// File: src/dfac_count.sv
// Transfer and block counters of the combined channel
`timescale 1ns/1ns
module dfac_count #(
  parameter int CW = 16
)
(
  input wire logic clk,
  input wire logic block_mode,
  input wire logic step,
  input wire logic wr_first,
  input wire logic [CW-1:0] wr_first_val,
  input wire logic wr_second,
  input wire logic [CW-1:0] wr_second_val,
  output logic [CW-1:0] count_first,
  output logic [CW-1:0] count_second,
  output logic last
);
  localparam int HW = CW / 2;
  logic [HW-1:0] size_now;
  assign size_now = count_first[CW-1:HW];
  // Last transfer of the sequence: this step brings the governing count to zero
  always_comb
  begin
    if (block_mode)
      last = (size_now == HW'(1)) && (count_second == CW'(1));
    else
      last = (count_first == CW'(1));
  end

  // No reset: counts keep their contents over reset and standby
  always_ff @(posedge clk)
  begin
    if (wr_first)
      count_first <= wr_first_val;
    else if (step && !block_mode)
      count_first <= count_first - CW'(1);
    else if (step && block_mode)
    begin
      if (size_now == HW'(1))
        count_first[CW-1:HW] <= count_first[HW-1:0];
      else
        count_first[CW-1:HW] <= size_now - HW'(1);
    end
  end

  // Second count is untouched in normal mode
  always_ff @(posedge clk)
  begin
    if (wr_second)
      count_second <= wr_second_val;
    else if (step && block_mode && size_now == HW'(1))
      count_second <= count_second - CW'(1);
  end
endmodule : dfac_count

// File: src/dfac_top.sv
// DMA channel pair in full address mode: control register, counters, enables and source stepping
// Functional notes
// - normal mode: first count decrements per transfer, ends at zero.
// - normal mode ignores the second count.
// - block mode: upper byte of first count is block size counter.
// - block size counter reloads from lower byte at zero.
// - block mode: second count counts blocks, ends at zero.
// - counts are not touched by reset or standby.
// - full address mode when both upper select bits are one.
// - first control register clears on reset and standby.
// - channel enabled only when enable and master enable both set.
// - auto-request starts at once; otherwise wait for requests.
// - enable bit clears itself when all transfers are done.
// - with enable clear, requests are ignored.
// - enable bit sets only on a write of one after reading it zero.
// - end interrupt raised on enable clear when its enable bit is one.
// - size bit selects byte or word transfer.
// - source address fixed or steps up or down by 1 or 2.
// - lowest control bit selects normal or block mode.
// - first address register is source, second is destination.
// - non-maskable interrupt clears master enable; setting it again resumes.
`timescale 1ns/1ns
`include "dfac_map.svh"
module dfac_top
  import dfac_pkg::*;
#(
  parameter int AW = 32,
  parameter int CW = 16
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic STANDBY,
  input wire logic NMI,
  input wire logic XFER_REQ,
  input wire logic XFER_DONE,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic S_AXI_BVALID,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic S_AXI_RVALID,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RREADY,
  output logic XFER_GO,
  output logic XFER_WORD,
  output logic [AW-1:0] SRC_ADDR,
  output logic [AW-1:0] DST_ADDR,
  output logic TRANSFER_END_INTERRUPT,
  output logic FULL_MODE
);
  logic wr_stb;
  dfac_wreq_t wr_req;
  logic wr_err;
  logic rd_stb;
  logic [7:0] rd_addr;
  dfac_rresp_t rd_resp;
  logic [7:0] channel_control_first;
  logic [7:0] channel_control_second;
  logic [AW-1:0] source_address_reg;
  logic [AW-1:0] destination_address_reg;
  logic [CW-1:0] transfer_count_first;
  logic [CW-1:0] transfer_count_second;
  logic enable_seen_zero;
  logic master_seen_zero;
  logic last;
  logic step;
  logic auto_req;
  logic clear_enable;
  dfac_state_t state;
  dfac_state_t next_state;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction : hit

  function automatic logic [AW-1:0] stepped(input logic [AW-1:0] a, input logic word, input logic down);
    logic [AW-1:0] d;
    d = word ? AW'(`DFAC_STEP_WORD) : AW'(`DFAC_STEP_BYTE);
    stepped = down ? a - d : a + d;
  endfunction : stepped

  dfac_axil i_dfac_axil (
    .clk(CLK),
    .rst_n(RST_N),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bvalid(S_AXI_BVALID),
    .bresp(S_AXI_BRESP),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rvalid(S_AXI_RVALID),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rready(S_AXI_RREADY),
    .wr_stb(wr_stb),
    .wr_req(wr_req),
    .wr_err(wr_err),
    .rd_stb(rd_stb),
    .rd_addr(rd_addr),
    .rd_resp(rd_resp)
  );

  logic wr_cnt1;
  logic wr_cnt2;
  logic [CW-1:0] cnt1_val;
  logic [CW-1:0] cnt2_val;
  logic [7:0] wa;
  assign wa = wr_req.addr[7:0];
  assign wr_cnt1 = wr_stb && hit(wa, `DFAC_OFF_COUNT_FIRST) && (wr_req.strb[1:0] != 2'b00);
  assign wr_cnt2 = wr_stb && hit(wa, `DFAC_OFF_COUNT_SECOND) && (wr_req.strb[1:0] != 2'b00);
  assign cnt1_val = {wr_req.strb[1] ? wr_req.data[15:8] : transfer_count_first[15:8],
                     wr_req.strb[0] ? wr_req.data[7:0] : transfer_count_first[7:0]};
  assign cnt2_val = {wr_req.strb[1] ? wr_req.data[15:8] : transfer_count_second[15:8],
                     wr_req.strb[0] ? wr_req.data[7:0] : transfer_count_second[7:0]};
  // Writes to unmapped words get an error response and change nothing
  assign wr_err = !(hit(wa, `DFAC_OFF_COUNT_FIRST) || hit(wa, `DFAC_OFF_COUNT_SECOND)
                 || hit(wa, `DFAC_OFF_CTRL_FIRST) || hit(wa, `DFAC_OFF_CTRL_SECOND)
                 || hit(wa, `DFAC_OFF_SRC_ADDR) || hit(wa, `DFAC_OFF_DST_ADDR)
                 || hit(wa, `DFAC_OFF_STATUS) || hit(wa, `DFAC_OFF_CONTROL));

  dfac_count #(
    .CW(CW)
  ) i_dfac_count (
    .clk(CLK),
    .block_mode(channel_control_first[`DFAC_BIT_BLOCK]),
    .step(step),
    .wr_first(wr_cnt1),
    .wr_first_val(cnt1_val),
    .wr_second(wr_cnt2),
    .wr_second_val(cnt2_val),
    .count_first(transfer_count_first),
    .count_second(transfer_count_second),
    .last(last)
  );

  logic full_mode;
  logic enabled;
  assign full_mode = channel_control_first[`DFAC_BIT_FULL_HI] && channel_control_first[`DFAC_BIT_FULL_LO];
  assign enabled = full_mode && channel_control_first[`DFAC_BIT_ENABLE]
                   && channel_control_second[`DFAC_BIT_MASTER];
  // Both auto-request codes start without an external request
  assign auto_req = (channel_control_second[2:0] == `DFAC_SRC_AUTO_BURST)
                    || (channel_control_second[2:0] == `DFAC_SRC_AUTO_STEAL);
  // A completion counts only while a transfer is open and the channel is still enabled
  assign step = (state == DFAC_MOVE) && XFER_DONE && enabled;
  assign clear_enable = step && last;

  // Channel sequencer: armed waits for a request, move holds one transfer outstanding
  always_comb
  begin
    next_state = state;
    case (state)
      DFAC_IDLE:
        if (enabled)
          next_state = DFAC_ARMED;
      DFAC_ARMED:
        if (!enabled)
          next_state = DFAC_IDLE;
        else if (auto_req || XFER_REQ)
          next_state = DFAC_MOVE;
      DFAC_MOVE:
        if (!enabled)
          next_state = DFAC_IDLE;
        else if (XFER_DONE)
          next_state = last ? DFAC_IDLE : DFAC_ARMED;
      default:
        next_state = DFAC_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      state <= DFAC_IDLE;
    else if (STANDBY)
      state <= DFAC_IDLE;
    else
      state <= next_state;
  end

  // First control register with read-before-set guard on the enable bit
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      channel_control_first <= `DFAC_CTRL_RESET;
      enable_seen_zero <= 1'b0;
    end
    else if (STANDBY)
    begin
      channel_control_first <= `DFAC_CTRL_RESET;
      enable_seen_zero <= 1'b0;
    end
    else
    begin
      if (wr_stb && hit(wa, `DFAC_OFF_CTRL_FIRST) && wr_req.strb[0])
      begin
        channel_control_first[6:0] <= wr_req.data[6:0];
        if (!wr_req.data[`DFAC_BIT_ENABLE])
          channel_control_first[`DFAC_BIT_ENABLE] <= 1'b0;
        else if (enable_seen_zero)
          channel_control_first[`DFAC_BIT_ENABLE] <= 1'b1;
        enable_seen_zero <= 1'b0;
      end
      // Read-zero mark comes after the write so a same-cycle read still counts
      if (rd_stb && hit(rd_addr, `DFAC_OFF_CTRL_FIRST) && !channel_control_first[`DFAC_BIT_ENABLE])
        enable_seen_zero <= 1'b1;
      // Hardware clear comes last so it beats a same-cycle software set
      if (clear_enable)
        channel_control_first[`DFAC_BIT_ENABLE] <= 1'b0;
    end
  end

  // Second control register; NMI wins over a software set of master enable
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      channel_control_second <= `DFAC_CTRL_RESET;
      master_seen_zero <= 1'b0;
    end
    else if (STANDBY)
    begin
      channel_control_second <= `DFAC_CTRL_RESET;
      master_seen_zero <= 1'b0;
    end
    else
    begin
      if (wr_stb && hit(wa, `DFAC_OFF_CTRL_SECOND) && wr_req.strb[0])
      begin
        channel_control_second[6:0] <= wr_req.data[6:0];
        if (!wr_req.data[`DFAC_BIT_MASTER])
          channel_control_second[`DFAC_BIT_MASTER] <= 1'b0;
        else if (master_seen_zero)
          channel_control_second[`DFAC_BIT_MASTER] <= 1'b1;
        master_seen_zero <= 1'b0;
      end
      // Read-zero mark after the write, as for the enable bit
      if (rd_stb && hit(rd_addr, `DFAC_OFF_CTRL_SECOND) && !channel_control_second[`DFAC_BIT_MASTER])
        master_seen_zero <= 1'b1;
      if (NMI)
        channel_control_second[`DFAC_BIT_MASTER] <= 1'b0;
    end
  end

  // Source steps after each transfer when its step bit is set, otherwise stays fixed; destination is held by this block
  always_ff @(posedge CLK)
  begin
    if (wr_stb && hit(wa, `DFAC_OFF_SRC_ADDR))
      source_address_reg <= wr_req.data[AW-1:0];
    else if (step && channel_control_first[`DFAC_BIT_SRC_STEP])
      source_address_reg <= stepped(source_address_reg, channel_control_first[`DFAC_BIT_SIZE],
                                    channel_control_first[`DFAC_BIT_SRC_DIR]);
  end

  always_ff @(posedge CLK)
  begin
    if (wr_stb && hit(wa, `DFAC_OFF_DST_ADDR))
      destination_address_reg <= wr_req.data[AW-1:0];
  end

  // Read mux
  always_comb
  begin
    rd_resp.resp = `DFAC_RESP_OKAY;
    rd_resp.data = 32'h00000000;
    if (hit(rd_addr, `DFAC_OFF_COUNT_FIRST))
      rd_resp.data = {16'h0000, transfer_count_first};
    else if (hit(rd_addr, `DFAC_OFF_COUNT_SECOND))
      rd_resp.data = {16'h0000, transfer_count_second};
    else if (hit(rd_addr, `DFAC_OFF_CTRL_FIRST))
      rd_resp.data = {24'h000000, channel_control_first};
    else if (hit(rd_addr, `DFAC_OFF_CTRL_SECOND))
      rd_resp.data = {24'h000000, channel_control_second};
    else if (hit(rd_addr, `DFAC_OFF_SRC_ADDR))
      rd_resp.data = source_address_reg;
    else if (hit(rd_addr, `DFAC_OFF_DST_ADDR))
      rd_resp.data = destination_address_reg;
    else if (hit(rd_addr, `DFAC_OFF_STATUS))
      rd_resp.data = {28'h0000000, full_mode, enabled, state};
    // Reserved word reads as zero with an okay response; any other word is an error
    else if (!hit(rd_addr, `DFAC_OFF_CONTROL))
      rd_resp.resp = `DFAC_RESP_SLVERR;
  end

  // Registered outputs
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      XFER_GO <= 1'b0;
      XFER_WORD <= 1'b0;
      SRC_ADDR <= '0;
      DST_ADDR <= '0;
      FULL_MODE <= 1'b0;
    end
    else
    begin
      // Standby drops the request on the same edge that clears the state
      XFER_GO <= (next_state == DFAC_MOVE) && !STANDBY;
      XFER_WORD <= channel_control_first[`DFAC_BIT_SIZE];
      SRC_ADDR <= source_address_reg;
      DST_ADDR <= destination_address_reg;
      FULL_MODE <= full_mode;
    end
  end

  // End interrupt: pulse when the enable bit falls, gated by its enable
  logic enable_q;
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      enable_q <= 1'b0;
      TRANSFER_END_INTERRUPT <= 1'b0;
    end
    else
    begin
      enable_q <= channel_control_first[`DFAC_BIT_ENABLE];
      TRANSFER_END_INTERRUPT <= enable_q && !channel_control_first[`DFAC_BIT_ENABLE]
                                && channel_control_first[`DFAC_BIT_END_IE];
    end
  end
endmodule : dfac_top
